// >>> etc_pkg.sv
// shared constants and types for the event timer counter core
package etc_pkg;

   // ---------------------------------------------------------------
   // data widths
   // ---------------------------------------------------------------
   localparam int DATA_W    = 8;
   localparam int PSC_CNT_W = 8;
   localparam int PSC_W     = 3;
   localparam int GATE_N    = 2;

   // ---------------------------------------------------------------
   // register byte offsets on the avalon slave
   // ---------------------------------------------------------------
   localparam logic [3:0] OFS_COUNT = 4'h0;
   localparam logic [3:0] OFS_CTRL  = 4'h4;
   localparam logic [3:0] OFS_INTC  = 4'h8;
   localparam logic [3:0] OFS_STAT  = 4'hc;

   // ---------------------------------------------------------------
   // counter0_control fields
   // ---------------------------------------------------------------
   localparam int CTRL_PSC_LSB  = 0;
   localparam int CTRL_EDGE_BIT = 3;
   localparam int CTRL_EN_BIT   = 4;
   localparam int CTRL_SRC_BIT  = 5;
   localparam int CTRL_MODE_LSB = 6;

   localparam logic [1:0] MODE_OFF   = 2'h0;
   localparam logic [1:0] MODE_EVENT = 2'h1;
   localparam logic [1:0] MODE_TIMER = 2'h2;
   localparam logic [1:0] MODE_PWM   = 2'h3;

   // ---------------------------------------------------------------
   // interrupt_control_0 and status fields
   // ---------------------------------------------------------------
   localparam int INTC_MASTER_BIT = 0;
   localparam int INTC_EN_BIT     = 1;
   localparam int INTC_FLAG_BIT   = 2;
   localparam int STAT_PDN_BIT    = 0;
   localparam int STAT_MEAS_BIT   = 1;

   // ---------------------------------------------------------------
   // reset values and fixed codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_RST    = 8'h00;
   localparam logic [7:0] COUNT_RST   = 8'h00;
   localparam logic [7:0] COUNT_FULL  = 8'hff;
   localparam logic [7:0] VECTOR_ADDR = 8'h10;

   typedef enum logic [2:0] {
      PWM_WAIT = 3'b001,
      PWM_RUN  = 3'b010,
      PWM_DONE = 3'b100
   } etc_pwm_state_e;

endpackage

// >>> etc_in_sync.sv
// three-stage synchroniser with agreement filter for one asynchronous input
`timescale 1ns/1ps
module etc_in_sync (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // asynchronous input and its clean level
   input  wire logic async_in,
   output logic      level_out
);

   logic ff1_reg;
   logic ff2_reg;
   logic ff3_reg;
   logic level_next;

   // a change only counts once stages two and three agree
   assign level_next = (ff2_reg == ff3_reg) ? ff3_reg : level_out;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ff1_reg   <= 1'b0;
         ff2_reg   <= 1'b0;
         ff3_reg   <= 1'b0;
         level_out <= 1'b0;
      end else begin
         ff1_reg   <= async_in;
         ff2_reg   <= ff1_reg;
         ff3_reg   <= ff2_reg;
         level_out <= level_next;
      end
   end

endmodule

// >>> etc_prescaler.sv
// free-running prescaler giving a one-cycle timer clock tick every 2**psc cycles
`timescale 1ns/1ps
module etc_prescaler (
   // clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        rst_n,
   // division select
   input  wire logic [etc_pkg::PSC_W-1:0]   psc_sel,
   // timer clock tick
   output logic                             tick
);

   logic [etc_pkg::PSC_CNT_W-1:0] cnt_reg;
   logic [etc_pkg::PSC_CNT_W-1:0] cnt_next;
   logic [etc_pkg::PSC_CNT_W-1:0] mask;
   logic                          tick_next;

   assign cnt_next  = cnt_reg + 8'h01;
   assign mask      = (8'h01 << psc_sel) - 8'h01;
   assign tick_next = (cnt_reg & mask) == mask;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_reg <= 8'h00;
         tick    <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick    <= tick_next;
      end
   end

endmodule

// >>> etc_event_timer_counter_core.sv
// timer / event counter / pulse width counter with avalon-mm register slave
//
// Operation
// - timer mode counts prescaled clock, overflow interrupts
// - pulse mode counts only while gate active
// - gate change seen at next timer tick
// - event inputs synchronised before counting
// - counting blocked during count read or preload write
// - interrupt forwarded only when enable bit set
// - enable bit starts and stops counter
// - overflow sets interrupt request flag
// - overflow wakes device in sleep or idle; the core only raises wake_up while power_down is high
// - event counting continues in power-down, wakes
// - flag already set suppresses new wake-up
// - control bit 4 is the enable
// - overflow interrupt vectors to address 10h
// - control 081h gives timer mode, divide by 2
// - overflow reloads preload and keeps counting
// - mode bits 11 select pulse width mode
// - pulse end clears enable, later edges ignored
// - edge bit low starts on falling edge
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module etc_event_timer_counter_core (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // gate and event inputs
   input  wire logic        ext_count_pin_a,
   input  wire logic        comparator_out_gate,
   // system power state
   input  wire logic        power_down,
   // processor side
   output logic             irq,
   output logic [7:0]       irq_vector,
   output logic             wake_up
);

   // ---------------------------------------------------------------
   // decoding helper
   // ---------------------------------------------------------------
   function automatic logic ofs_hit(input logic [3:0] addr, input logic [3:0] ofs);
      ofs_hit = (addr == ofs);
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [7:0]              count_reg;
   logic [7:0]              count_next;
   logic [7:0]              preload_reg;
   logic [7:0]              preload_next;
   logic [7:0]              ctrl_reg;
   logic [7:0]              ctrl_next;
   logic                    master_en_reg;
   logic                    master_en_next;
   logic                    ovf_en_reg;
   logic                    ovf_en_next;
   logic                    flag_reg;
   logic                    flag_next;
   logic                    samp_reg;
   logic                    samp_next;
   logic                    act_prev_reg;
   logic                    irq_next;
   logic                    wake_next;
   logic [31:0]             rdata_next;
   logic                    wait_next;
   etc_pkg::etc_pwm_state_e pwm_state_reg;
   etc_pkg::etc_pwm_state_e pwm_state_next;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   logic                    req;
   logic                    take;
   logic                    wr_take;
   logic                    hit_count;
   logic                    hit_ctrl;
   logic                    hit_intc;
   logic                    hit_stat;
   logic                    wr_count;
   logic                    wr_ctrl;
   logic                    wr_intc;
   logic                    inhibit;
   logic [7:0]              wbyte;

   assign req       = avs_read | avs_write;
   assign take      = req & ~avs_waitrequest;
   assign wr_take   = take & avs_write & avs_byteenable[0];
   assign hit_count = ofs_hit(avs_address, etc_pkg::OFS_COUNT);
   assign hit_ctrl  = ofs_hit(avs_address, etc_pkg::OFS_CTRL);
   assign hit_intc  = ofs_hit(avs_address, etc_pkg::OFS_INTC);
   assign hit_stat  = ofs_hit(avs_address, etc_pkg::OFS_STAT);
   assign wr_count  = wr_take & hit_count;
   assign wr_ctrl   = wr_take & hit_ctrl;
   assign wr_intc   = wr_take & hit_intc;
   assign wbyte     = avs_writedata[7:0];

   // the whole pending access holds the count still, so the captured
   // read word and the preload store never race an increment
   assign inhibit   = req & hit_count;

   // ---------------------------------------------------------------
   // control field views
   // ---------------------------------------------------------------
   logic [1:0]              mode;
   logic                    run_en;
   logic                    edge_hi;
   logic                    src_cmp;
   logic [2:0]              psc_sel;
   logic                    mode_timer;
   logic                    mode_event;
   logic                    mode_pwm;

   assign mode       = ctrl_reg[etc_pkg::CTRL_MODE_LSB +: 2];
   assign run_en     = ctrl_reg[etc_pkg::CTRL_EN_BIT];
   assign edge_hi    = ctrl_reg[etc_pkg::CTRL_EDGE_BIT];
   assign src_cmp    = ctrl_reg[etc_pkg::CTRL_SRC_BIT];
   assign psc_sel    = ctrl_reg[etc_pkg::CTRL_PSC_LSB +: etc_pkg::PSC_W];
   assign mode_timer = (mode == etc_pkg::MODE_TIMER);
   assign mode_event = (mode == etc_pkg::MODE_EVENT);
   assign mode_pwm   = (mode == etc_pkg::MODE_PWM);

   // ---------------------------------------------------------------
   // input synchronisers and timer clock
   // ---------------------------------------------------------------
   logic [etc_pkg::GATE_N-1:0] raw_in;
   logic [etc_pkg::GATE_N-1:0] sync_in;
   logic                       tick;

   assign raw_in = {comparator_out_gate, ext_count_pin_a};

   genvar gi;
   generate
      for (gi = 0; gi < etc_pkg::GATE_N; gi = gi + 1) begin : g_sync
         // inputs are unrelated to sys_clk and are resynchronised first
         etc_in_sync u_sync (
            .sys_clk   (sys_clk),
            .rst_n     (rst_n),
            .async_in  (raw_in[gi]),
            .level_out (sync_in[gi])
         );
      end
   endgenerate

   // free-running, so the first tick after enabling may come early
   etc_prescaler u_psc (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .psc_sel (psc_sel),
      .tick    (tick)
   );

   // ---------------------------------------------------------------
   // active level and edges
   // ---------------------------------------------------------------
   logic                    gate_level;
   logic                    act;
   logic                    ev_edge;
   logic                    tick_edge;

   assign gate_level = src_cmp ? sync_in[1] : sync_in[0];
   // edge bit low makes low the active level, so a falling edge starts
   assign act        = edge_hi ? gate_level : ~gate_level;
   // each transition into the active level is one event
   assign ev_edge    = act & ~act_prev_reg;
   // the gate is only looked at on a timer tick, costing up to one tick
   assign samp_next  = tick ? act : samp_reg;
   assign tick_edge  = tick & act & ~samp_reg;

   // ---------------------------------------------------------------
   // pulse width sequencer
   // ---------------------------------------------------------------
   logic                    pwm_step;
   logic                    pwm_end;
   logic                    meas_run;

   // measurement in progress, also shown in the status register
   assign meas_run = (pwm_state_reg == etc_pkg::PWM_RUN);
   assign pwm_end  = meas_run & tick & ~act;
   assign pwm_step = (meas_run & tick & act) |
                     ((pwm_state_reg == etc_pkg::PWM_WAIT) & tick_edge);

   always_comb begin
      pwm_state_next = pwm_state_reg;
      if (!(mode_pwm & run_en)) begin
         pwm_state_next = etc_pkg::PWM_WAIT;
      end else begin
         case (pwm_state_reg)
            etc_pkg::PWM_WAIT: begin
               if (tick_edge) begin
                  pwm_state_next = etc_pkg::PWM_RUN;
               end
            end
            etc_pkg::PWM_RUN: begin
               if (pwm_end) begin
                  pwm_state_next = etc_pkg::PWM_DONE;
               end
            end
            etc_pkg::PWM_DONE: begin
               pwm_state_next = etc_pkg::PWM_WAIT;
            end
            default: begin
               pwm_state_next = etc_pkg::PWM_WAIT;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // count step selection
   // ---------------------------------------------------------------
   logic                    step;
   logic                    run;
   logic                    ovf;

   assign step = (mode_timer & tick) |
                 (mode_event & ev_edge) |
                 (mode_pwm & pwm_step);
   // inhibit only masks steps while the access is pending
   assign run  = run_en & step & ~inhibit;
   assign ovf  = run & (count_reg == etc_pkg::COUNT_FULL);

   // ---------------------------------------------------------------
   // next values
   // ---------------------------------------------------------------
   // preload writes while running spare the live count
   always_comb begin
      count_next = count_reg;
      if (wr_count & ~run_en) begin
         count_next = wbyte;
      end else if (ovf) begin
         count_next = preload_reg;
      end else if (run) begin
         count_next = count_reg + 8'h01;
      end
   end

   assign preload_next = wr_count ? wbyte : preload_reg;

   // a write in the same cycle beats the hardware clear
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = wbyte;
      end else if (pwm_end) begin
         ctrl_next[etc_pkg::CTRL_EN_BIT] = 1'b0;
      end
   end

   assign master_en_next = wr_intc ? wbyte[etc_pkg::INTC_MASTER_BIT] : master_en_reg;
   assign ovf_en_next    = wr_intc ? wbyte[etc_pkg::INTC_EN_BIT] : ovf_en_reg;

   // hardware set wins over a clearing write in the same cycle
   assign flag_next = ovf | (wr_intc ? wbyte[etc_pkg::INTC_FLAG_BIT] : flag_reg);

   // wake-up ignores the enables; a flag already high keeps it quiet
   assign wake_next = ovf & power_down & ~flag_reg;

   assign irq_next  = flag_reg & ovf_en_reg & master_en_reg;

   // ---------------------------------------------------------------
   // avalon read path
   // ---------------------------------------------------------------
   logic [7:0]              rd_count;
   logic [7:0]              rd_ctrl;
   logic [7:0]              rd_intc;
   logic [7:0]              rd_stat;
   logic [7:0]              rd_byte;

   assign rd_count = hit_count ? count_reg : 8'h00;
   assign rd_ctrl  = hit_ctrl ? ctrl_reg : 8'h00;
   assign rd_intc  = hit_intc ? {5'h00, flag_reg, ovf_en_reg, master_en_reg} : 8'h00;
   assign rd_stat  = hit_stat ? {6'h00, meas_run, power_down} : 8'h00;
   assign rd_byte  = rd_count | rd_ctrl | rd_intc | rd_stat;

   // one wait cycle: the word is captured when the request is first seen
   assign rdata_next = (req & avs_waitrequest & avs_read) ? {24'h000000, rd_byte} : avs_readdata;
   assign wait_next  = ~(req & avs_waitrequest);

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         count_reg     <= etc_pkg::COUNT_RST;
         preload_reg   <= etc_pkg::COUNT_RST;
         ctrl_reg      <= etc_pkg::CTRL_RST;
         master_en_reg <= 1'b0;
         ovf_en_reg    <= 1'b0;
         flag_reg      <= 1'b0;
         pwm_state_reg <= etc_pkg::PWM_WAIT;
      end else begin
         count_reg     <= count_next;
         preload_reg   <= preload_next;
         ctrl_reg      <= ctrl_next;
         master_en_reg <= master_en_next;
         ovf_en_reg    <= ovf_en_next;
         flag_reg      <= flag_next;
         pwm_state_reg <= pwm_state_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         samp_reg     <= 1'b0;
         act_prev_reg <= 1'b0;
      end else begin
         samp_reg     <= samp_next;
         act_prev_reg <= act;
      end
   end

   // every top-level output leaves straight from a flop
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         avs_readdata    <= 32'h00000000;
         avs_waitrequest <= 1'b1;
         irq             <= 1'b0;
         wake_up         <= 1'b0;
         irq_vector      <= etc_pkg::VECTOR_ADDR;
      end else begin
         avs_readdata    <= rdata_next;
         avs_waitrequest <= wait_next;
         irq             <= irq_next;
         wake_up         <= wake_next;
         irq_vector      <= etc_pkg::VECTOR_ADDR;
      end
   end

endmodule

// >>> etc_event_timer_counter_core_monitor.sv
// concurrent checks on the ports of the event timer counter core
`timescale 1ns/1ps
module etc_event_timer_counter_core_monitor (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rst_n,
   // avalon-mm slave
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // gate inputs and power state
   input wire logic        ext_count_pin_a,
   input wire logic        comparator_out_gate,
   input wire logic        power_down,
   // processor side
   input wire logic        irq,
   input wire logic [7:0]  irq_vector,
   input wire logic        wake_up
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // ---------------------------------------------------------------
   // shadow of master and overflow enables, taken at the completing edge
   // ---------------------------------------------------------------
   wire  intc_wr = avs_write && !avs_waitrequest && avs_address == etc_pkg::OFS_INTC && avs_byteenable[0];
   logic en_ok_reg;
   wire  en_ok_next = intc_wr ? &avs_writedata[1:0] : en_ok_reg;
   always_ff @(posedge sys_clk) begin
      en_ok_reg <= rst_n ? en_ok_next : 1'b0;
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("access not answered after one wait cycle");
   a_wait_single_low: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_vector_fixed: assert property (irq_vector == 8'h10)
      else $error("interrupt vector is not 10h");
   a_irq_needs_enable: assert property (irq |-> $past(en_ok_reg))
      else $error("irq raised with an enable bit clear");
   a_irq_drops_off: assert property (intc_wr && !(&avs_writedata[1:0]) |-> ##2 !irq)
      else $error("irq still high after enables cleared");
   a_wake_power_down: assert property (wake_up |-> power_down || $past(power_down))
      else $error("wake-up outside power-down");
   a_wake_one_pulse: assert property (wake_up |=> !wake_up)
      else $error("wake-up longer than one cycle");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'b00
                                     |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");

   c_irq: cover property (irq);
   c_wake: cover property (wake_up);
   c_count_read: cover property (avs_read && !avs_waitrequest && avs_address == etc_pkg::OFS_COUNT);
   c_pulse_gates: cover property (!comparator_out_gate && !ext_count_pin_a);
endmodule

bind etc_event_timer_counter_core etc_event_timer_counter_core_monitor i_mon (
   .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_count_pin_a(ext_count_pin_a),
   .comparator_out_gate(comparator_out_gate), .power_down(power_down), .irq(irq),
   .irq_vector(irq_vector), .wake_up(wake_up));

// >>> etc_gate_source.sv
// pin and comparator source standing at the gate side of the counter
`timescale 1ns/1ps
module etc_gate_source (
   // clock
   input wire logic sys_clk,
   // gate lines
   output logic     ext_count_pin_a,
   output logic     comparator_out_gate
);
   // idle pin low and comparator high, so both start polarities can be tried
   initial begin
      ext_count_pin_a = 1'b0;
      comparator_out_gate = 1'b1;
   end
   // hold one line at lvl for w clocks, then drive it to the inverse of lvl
   task automatic pulse(input bit sel, input bit lvl, input int w);
      @(posedge sys_clk);
      if (sel) comparator_out_gate <= lvl; else ext_count_pin_a <= lvl;
      repeat (w) @(posedge sys_clk);
      if (sel) comparator_out_gate <= !lvl; else ext_count_pin_a <= !lvl;
   endtask
endmodule

// >>> etc_event_timer_counter_core_tb.sv
// self-checking bench for the event timer counter core
`timescale 1ns/1ps
module etc_event_timer_counter_core_tb;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic        power_down = 1'b0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        ext_count_pin_a;
   logic        comparator_out_gate;
   logic        irq;
   logic [7:0]  irq_vector;
   logic        wake_up;
   logic [7:0]  q;
   logic [7:0]  q2;
   int          failures = 0;
   int          compares = 0;
   int          wakes = 0;
   int          irqs = 0;
   int          seed = 32'hf0be073b;
   int          w;
   int          mreg [0:3] = '{default: 0};

   etc_event_timer_counter_core i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ext_count_pin_a(ext_count_pin_a), .comparator_out_gate(comparator_out_gate),
      .power_down(power_down), .irq(irq), .irq_vector(irq_vector), .wake_up(wake_up));
   etc_gate_source i_src (.sys_clk(sys_clk), .ext_count_pin_a(ext_count_pin_a),
      .comparator_out_gate(comparator_out_gate));

   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (wake_up === 1'b1) wakes++;
      if (irq === 1'b1) irqs++;
   end

   // ---------------------------------------------------------------
   // bus access, model update and comparisons
   // ---------------------------------------------------------------
   function automatic void fail(input string m);
      $display("CHECK FAILED at %0t: %s", $time, m);
      failures++;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      compares++;
      if (got !== exp) fail(m);
   endtask
   task automatic rng(input logic [7:0] got, input int lo, input int hi, input string m);
      compares++;
      if ($isunknown(got) || got < lo || got > hi) fail(m);
   endtask
   task automatic bus(input bit wr, input logic [3:0] a, input logic [7:0] d, input bit be);
      @(posedge sys_clk);
      avs_address    <= a;
      avs_write      <= wr;
      avs_read       <= !wr;
      avs_writedata  <= {24'h0, d};
      avs_byteenable <= {3'h0, be};
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (wr && be && a[1:0] == 2'b00) mreg[a[3:2]] = d;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 1'b1);
   endtask
   task automatic rd(input logic [3:0] a);
      bus(1'b0, a, 8'h00, 1'b1);
   endtask
   task automatic end_of_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge sys_clk);
      fail("watchdog expired");
      end_of_test();
   end

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      chk(irq_vector, 8'h10, "vector");
      for (int i = 0; i < 4; i++) begin
         rd(4'(4 * i));
         chk(q, 8'h00, "reset value");
      end
      rd(4'h2);
      chk(q, 8'h00, "unmapped read");
      wr(4'h6, 8'h2f);
      bus(1'b1, etc_pkg::OFS_CTRL, 8'h2f, 1'b0);
      rd(etc_pkg::OFS_CTRL);
      chk(q, 8'(mreg[1]), "ignored writes");
      for (int i = 0; i < 4; i++) begin
         w = $random(seed);
         wr(etc_pkg::OFS_CTRL, 8'(w) & 8'h2f);
         rd(etc_pkg::OFS_CTRL);
         chk(q, 8'(mreg[1]), "control readback");
         wr(etc_pkg::OFS_INTC, 8'(w >> 8) & 8'h03);
         rd(etc_pkg::OFS_INTC);
         chk(q, 8'(mreg[2]), "intc readback");
      end
      $display("test registers done");
      wr(etc_pkg::OFS_CTRL, 8'h00);
      wr(etc_pkg::OFS_COUNT, 8'hfb);
      wr(etc_pkg::OFS_INTC, 8'h03);
      wr(etc_pkg::OFS_CTRL, 8'h81);
      rd(etc_pkg::OFS_COUNT);
      chk(q, 8'hfb, "081h leaves counter stopped");
      wr(etc_pkg::OFS_CTRL, 8'h91);
      w = 0;
      while (irq !== 1'b1 && w < 100) begin
         @(posedge sys_clk);
         w++;
      end
      rng(8'(w), 8, 16, "five ticks at divide by 2");
      chk(irq_vector, 8'h10, "vector at interrupt");
      rd(etc_pkg::OFS_INTC);
      chk(q & 8'h04, 8'h04, "flag on overflow");
      rd(etc_pkg::OFS_COUNT);
      rng(q, 8'hfb, 8'hff, "reload from preload");
      wr(etc_pkg::OFS_CTRL, 8'h81);
      wr(etc_pkg::OFS_COUNT, 8'h40);
      repeat (20) @(posedge sys_clk);
      rd(etc_pkg::OFS_COUNT);
      chk(q, 8'h40, "enable clear stops");
      wr(etc_pkg::OFS_INTC, 8'h03);
      wr(etc_pkg::OFS_INTC, 8'h00);
      $display("test timer done");
      wr(etc_pkg::OFS_COUNT, 8'h00);
      wr(etc_pkg::OFS_CTRL, 8'h90);
      rd(etc_pkg::OFS_COUNT);
      q2 = q;
      rd(etc_pkg::OFS_COUNT);
      rng(q - q2, 1, 2, "clock blocked during read");
      q2 = q;
      repeat (30) @(posedge sys_clk);
      rd(etc_pkg::OFS_COUNT);
      rng(q - q2, 28, 34, "counting resumes");
      wr(etc_pkg::OFS_CTRL, 8'h00);
      $display("test inhibit done");
      power_down <= 1'b1;
      wr(etc_pkg::OFS_COUNT, 8'hfd);
      wr(etc_pkg::OFS_CTRL, 8'h58);
      rd(etc_pkg::OFS_STAT);
      chk(q, 8'h01, "status power-down");
      wakes = 0;
      irqs = 0;
      for (int p = 0; p < 6; p++) begin
         if (p == 3) begin
            chk(8'(wakes), 8'd1, "wake on event overflow");
            rd(etc_pkg::OFS_INTC);
            chk(q, 8'h04, "flag without enables");
            wr(etc_pkg::OFS_INTC, 8'h04);
         end
         i_src.pulse(1'b0, 1'b1, 8);
         repeat (10) @(posedge sys_clk);
      end
      chk(8'(wakes), 8'd1, "no wake with flag set");
      chk(8'(irqs), 8'd0, "interrupt held off");
      rd(etc_pkg::OFS_COUNT);
      chk(q, 8'hfd, "event count reloaded");
      wr(etc_pkg::OFS_CTRL, 8'h00);
      wr(etc_pkg::OFS_INTC, 8'h00);
      power_down <= 1'b0;
      $display("test event done");
      for (int k = 0; k < 2; k++) begin
         w = 20 + ($random(seed) & 31);
         wr(etc_pkg::OFS_COUNT, 8'h00);
         wr(etc_pkg::OFS_CTRL, k ? 8'hd8 : 8'hf0);
         repeat (6) @(posedge sys_clk);
         i_src.pulse(!k, k, w);
         repeat (20) @(posedge sys_clk);
         rd(etc_pkg::OFS_CTRL);
         chk(q, k ? 8'hc8 : 8'he0, "enable cleared at pulse end");
         rd(etc_pkg::OFS_COUNT);
         rng(q, w - 2, w + 2, "pulse width");
         i_src.pulse(!k, k, 10);
         repeat (20) @(posedge sys_clk);
         rd(etc_pkg::OFS_COUNT);
         rng(q, w - 2, w + 2, "later pulse ignored");
      end
      $display("test pulse width done");
      end_of_test();
   end
endmodule
